// >>> hw/reader_timer_unit.sv
// Overview of operation
// - after reload and start, count down from the chosen start event
// - a stop event before underflow halts the timer with no interrupt
// - without stop, count to zero, flag underflow on the next tick
// - wake timer expiry brings the system out of standby
// - with auto standby return and no card found, re-enter standby
// - wake timer counts edges of the low frequency oscillator
// - with auto standby return clear, stay powered after an empty detect
// - stop-watch: count from start, freeze counter at the stop event
// - every underflow sets the timer's sticky status bit
// - one-shot: interrupt pin rises once the interval has elapsed
// - auto reload with interrupt enabled gives periodic interrupts
// - four 16-bit counters, reload 0000 to ffff in two byte registers
// - timer clock is 13.56 MHz, 212 kHz or wake timer underflow
// - underflow either stops at zero or restarts from reload
// - shared control starts/stops each timer and shows running state
`timescale 1ns/1ns
`default_nettype none
module reader_timer_unit
  import timer_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wrEn,
  input  wire logic              rdEn,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              lfoClkPin,
  input  wire logic              startEvtPin,
  input  wire logic              stopEvtPin,
  input  wire logic              detectDone,
  input  wire logic              cardFound,
  output logic                   standbyOn,
  output logic                   irq
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [2:0]                      sync1;
    logic [2:0]                      sync2;
    logic                            lfoPrev;
    logic [ACC_W-1:0]                accFast;
    logic [ACC_W-1:0]                accSlow;
    logic                            tickFast;
    logic                            tickSlow;
    logic [NUM_TIMERS-1:0]           startCmd;
    logic [NUM_TIMERS-1:0]           stopCmd;
    logic [NUM_TIMERS-1:0][7:0]      ctrl;
    logic [NUM_TIMERS-1:0][CNT_W-1:0] reload;
    logic [7:0]                      irqStat;
    logic [7:0]                      irqMask;
    logic [7:0]                      wakeCtrl;
    logic [CNT_W-1:0]                wakeReload;
    logic [CNT_W-1:0]                wakeCnt;
    logic                            wakeUflow;
    logic                            standby;
    logic [DATA_W-1:0]               rdata;
  } top_t;

  top_t s_r;
  top_t s_nxt;

  logic [NUM_TIMERS-1:0]            chRunning;
  logic [NUM_TIMERS-1:0]            chUflow;
  logic [NUM_TIMERS-1:0][CNT_W-1:0] chCount;

  timer_ch_if chIf[NUM_TIMERS] ();

  // ****************************************************
  // address decoding
  // ****************************************************
  // true when a lies in the window of general timer idx
  function automatic logic timerHit(input logic [ADDR_W-1:0] a,
                                    input int unsigned      idx);
    logic [ADDR_W-1:0] base;
    base = TIMER_BASE_OFS + ADDR_W'(idx) * TIMER_STRIDE;
    return (a >= base) && (a < base + TIMER_STRIDE);
  endfunction

  // register within a timer window
  function automatic logic [2:0] timerSub(input logic [ADDR_W-1:0] a);
    return a[2:0];
  endfunction

  // ****************************************************
  // general timer channels
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : gen_ch
      assign chIf[g].startCmd   = s_r.startCmd[g];
      assign chIf[g].stopCmd    = s_r.stopCmd[g];
      assign chIf[g].reload     = s_r.reload[g];
      assign chIf[g].clkSel     = s_r.ctrl[g][TC_CLKSEL_LSB +: 2];
      assign chIf[g].autoReload = s_r.ctrl[g][TC_AUTO_POS];
      assign chIf[g].startSel   = s_r.ctrl[g][TC_STARTSEL_POS];
      assign chIf[g].stopEn     = s_r.ctrl[g][TC_STOPEN_POS];
      assign chIf[g].tickFast   = s_r.tickFast;
      assign chIf[g].tickSlow   = s_r.tickSlow;
      assign chIf[g].tickWake   = s_r.wakeUflow;
      assign chIf[g].startEvt   = s_r.sync2[1];
      assign chIf[g].stopEvt    = s_r.sync2[2];
      assign chRunning[g]       = chIf[g].running;
      assign chUflow[g]         = chIf[g].underflow;
      assign chCount[g]         = chIf[g].count;

      timer_channel u_ch (
        .clk  (clk),
        .nrst (nrst),
        .ch   (chIf[g])
      );
    end
  endgenerate

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [7:0]       irqSet;
    logic [7:0]       irqClr;
    logic [ACC_W:0]   sumF;
    logic [ACC_W:0]   sumS;
    logic             lfoEdge;
    irqSet  = 8'h00;
    irqClr  = 8'h00;
    sumF    = {1'b0, s_r.accFast} + {1'b0, FAST_KHZ};
    sumS    = {1'b0, s_r.accSlow} + {1'b0, SLOW_KHZ};
    lfoEdge = s_r.sync2[0] && !s_r.lfoPrev;
    s_nxt   = s_r;

    // pin synchronisers
    s_nxt.sync1   = {stopEvtPin, startEvtPin, lfoClkPin};
    s_nxt.sync2   = s_r.sync1;
    s_nxt.lfoPrev = s_r.sync2[0];

    s_nxt.tickFast = (sumF >= {1'b0, CLK_KHZ});
    s_nxt.accFast  = ACC_W'(s_nxt.tickFast ? sumF - {1'b0, CLK_KHZ} : sumF);
    s_nxt.tickSlow = (sumS >= {1'b0, CLK_KHZ});
    s_nxt.accSlow  = ACC_W'(s_nxt.tickSlow ? sumS - {1'b0, CLK_KHZ} : sumS);

    s_nxt.startCmd  = '0;
    s_nxt.stopCmd   = '0;
    s_nxt.wakeUflow = 1'b0;
    s_nxt.rdata     = '0;

    if (s_r.wakeCtrl[WC_RUN_POS] && lfoEdge) begin
      if (s_r.wakeCnt == COUNT_RST) begin
        s_nxt.wakeUflow            = 1'b1;
        irqSet[IRQ_WAKE_POS]       = 1'b1;
        s_nxt.standby              = 1'b0;
        if (s_r.wakeCtrl[WC_AUTO_RELOAD_POS]) begin
          s_nxt.wakeCnt = s_r.wakeReload;
        end else begin
          s_nxt.wakeCtrl[WC_RUN_POS] = 1'b0;
        end
      end else begin
        s_nxt.wakeCnt = s_r.wakeCnt - 16'h0001;
      end
    end

    // card detect outcome
    if (detectDone) begin
      if (cardFound) begin
        irqSet[IRQ_CARD_POS] = 1'b1;
      end else if (s_r.wakeCtrl[WC_AUTO_STBY_POS]) begin
        s_nxt.standby = 1'b1;
      end
    end

    irqSet[NUM_TIMERS-1:0] = chUflow;

    // register writes
    if (wrEn) begin
      unique case (addr)
        GLOBAL_CTRL_OFS: begin
          s_nxt.startCmd = wdata[GC_NOW_LSB +: NUM_TIMERS] &
                           wdata[GC_RUN_LSB +: NUM_TIMERS];
          s_nxt.stopCmd  = wdata[GC_NOW_LSB +: NUM_TIMERS] &
                           ~wdata[GC_RUN_LSB +: NUM_TIMERS];
        end
        IRQ_STATUS_OFS: irqClr = wdata;
        IRQ_MASK_OFS:   s_nxt.irqMask = wdata;
        WAKE_CTRL_OFS: begin
          s_nxt.wakeCtrl = wdata & ~(8'h01 << WC_ENTER_STBY_POS);
          if (wdata[WC_RUN_POS] && !s_r.wakeCtrl[WC_RUN_POS]) begin
            s_nxt.wakeCnt = s_r.wakeReload;
          end
          if (wdata[WC_ENTER_STBY_POS]) begin
            s_nxt.standby = 1'b1;
          end
        end
        WAKE_RELOAD_LO_OFS: s_nxt.wakeReload[7:0]  = wdata;
        WAKE_RELOAD_HI_OFS: s_nxt.wakeReload[15:8] = wdata;
        default: begin
          for (int i = 0; i < NUM_TIMERS; i++) begin
            if (timerHit(addr, i)) begin
              unique case (timerSub(addr))
                T_CTRL_SUB:      s_nxt.ctrl[i] = wdata;
                T_RELOAD_LO_SUB: s_nxt.reload[i][7:0]  = wdata;
                T_RELOAD_HI_SUB: s_nxt.reload[i][15:8] = wdata;
                default: begin
                end
              endcase
            end
          end
        end
      endcase
    end

    // status update, set wins over clear
    s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqSet;

    // register reads, unmapped read as zero
    if (rdEn) begin
      unique case (addr)
        GLOBAL_CTRL_OFS:    s_nxt.rdata = {4'h0, chRunning};
        IRQ_STATUS_OFS:     s_nxt.rdata = s_r.irqStat;
        IRQ_MASK_OFS:       s_nxt.rdata = s_r.irqMask;
        WAKE_CTRL_OFS:      s_nxt.rdata = s_r.wakeCtrl;
        WAKE_RELOAD_LO_OFS: s_nxt.rdata = s_r.wakeReload[7:0];
        WAKE_RELOAD_HI_OFS: s_nxt.rdata = s_r.wakeReload[15:8];
        WAKE_COUNT_LO_OFS:  s_nxt.rdata = s_r.wakeCnt[7:0];
        WAKE_COUNT_HI_OFS:  s_nxt.rdata = s_r.wakeCnt[15:8];
        default: begin
          for (int i = 0; i < NUM_TIMERS; i++) begin
            if (timerHit(addr, i)) begin
              unique case (timerSub(addr))
                T_CTRL_SUB:      s_nxt.rdata = s_r.ctrl[i];
                T_RELOAD_LO_SUB: s_nxt.rdata = s_r.reload[i][7:0];
                T_RELOAD_HI_SUB: s_nxt.rdata = s_r.reload[i][15:8];
                T_COUNT_LO_SUB:  s_nxt.rdata = chCount[i][7:0];
                T_COUNT_HI_SUB:  s_nxt.rdata = chCount[i][15:8];
                default:         s_nxt.rdata = '0;
              endcase
            end
          end
        end
      endcase
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r            <= '0;
      s_r.ctrl       <= {NUM_TIMERS{CTRL_RST}};
      s_r.reload     <= {NUM_TIMERS{RELOAD_RST}};
      s_r.irqStat    <= STATUS_RST;
      s_r.irqMask    <= MASK_RST;
      s_r.wakeCtrl   <= CTRL_RST;
      s_r.wakeReload <= RELOAD_RST;
      s_r.wakeCnt    <= COUNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign rdata     = s_r.rdata;
  assign standbyOn = s_r.standby;
  assign irq = |(s_r.irqStat & s_r.irqMask);

endmodule
`default_nettype wire

// >>> hw/timer_pkg.sv
package timer_pkg;

  // ****************************************************
  // sizes and clock rates
  // ****************************************************
  localparam int unsigned NUM_TIMERS = 4;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ACC_W      = 17;
  localparam logic [ACC_W-1:0] CLK_KHZ  = 17'h1e848; // 125000 kHz
  localparam logic [ACC_W-1:0] FAST_KHZ = 17'h034f8; // 13560 kHz
  localparam logic [ACC_W-1:0] SLOW_KHZ = 17'h000d4; // 212 kHz

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] GLOBAL_CTRL_OFS    = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h01;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h02;
  localparam logic [7:0] WAKE_CTRL_OFS      = 8'h03;
  localparam logic [7:0] WAKE_RELOAD_LO_OFS = 8'h04;
  localparam logic [7:0] WAKE_RELOAD_HI_OFS = 8'h05;
  localparam logic [7:0] WAKE_COUNT_LO_OFS  = 8'h06;
  localparam logic [7:0] WAKE_COUNT_HI_OFS  = 8'h07;
  localparam logic [7:0] TIMER_BASE_OFS     = 8'h10;
  localparam logic [7:0] TIMER_STRIDE       = 8'h08;
  localparam logic [2:0] T_CTRL_SUB         = 3'h0;
  localparam logic [2:0] T_RELOAD_LO_SUB    = 3'h1;
  localparam logic [2:0] T_RELOAD_HI_SUB    = 3'h2;
  localparam logic [2:0] T_COUNT_LO_SUB     = 3'h3;
  localparam logic [2:0] T_COUNT_HI_SUB     = 3'h4;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int unsigned GC_RUN_LSB        = 0;
  localparam int unsigned GC_NOW_LSB        = 4;
  localparam int unsigned TC_CLKSEL_LSB     = 0;
  localparam int unsigned TC_AUTO_POS       = 2;
  localparam int unsigned TC_STARTSEL_POS   = 3;
  localparam int unsigned TC_STOPEN_POS     = 4;
  localparam int unsigned WC_RUN_POS        = 0;
  localparam int unsigned WC_AUTO_RELOAD_POS = 1;
  localparam int unsigned WC_AUTO_STBY_POS  = 2;
  localparam int unsigned WC_ENTER_STBY_POS = 3;
  localparam int unsigned IRQ_WAKE_POS      = 4;
  localparam int unsigned IRQ_CARD_POS      = 5;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [7:0]       MASK_RST   = 8'h00;
  localparam logic [7:0]       STATUS_RST = 8'h00;
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_RST  = 16'h0000;

  // ****************************************************
  // timer clock sources
  // ****************************************************
  typedef enum logic [1:0] {
    SEL_FAST = 2'h0,
    SEL_SLOW = 2'h1,
    SEL_WAKE = 2'h2
  } clk_sel_t;

endpackage

// >>> hw/timer_ch_if.sv
`timescale 1ns/1ns
`default_nettype none
interface timer_ch_if;
  import timer_pkg::*;
  logic             startCmd;
  logic             stopCmd;
  logic [CNT_W-1:0] reload;
  logic [1:0]       clkSel;
  logic             autoReload;
  logic             startSel;
  logic             stopEn;
  logic             tickFast;
  logic             tickSlow;
  logic             tickWake;
  logic             startEvt;
  logic             stopEvt;
  logic [CNT_W-1:0] count;
  logic             running;
  logic             underflow;

  modport ctl (
    output startCmd, stopCmd, reload, clkSel, autoReload, startSel,
           stopEn, tickFast, tickSlow, tickWake, startEvt, stopEvt,
    input  count, running, underflow
  );
  modport chan (
    input  startCmd, stopCmd, reload, clkSel, autoReload, startSel,
           stopEn, tickFast, tickSlow, tickWake, startEvt, stopEvt,
    output count, running, underflow
  );
endinterface
`default_nettype wire

// >>> hw/timer_channel.sv
`timescale 1ns/1ns
`default_nettype none
module timer_channel
  import timer_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  timer_ch_if.chan  ch
);

  // ****************************************************
  // state
  // ****************************************************
  typedef enum logic [2:0] {
    CH_IDLE  = 3'b001,
    CH_ARMED = 3'b010,
    CH_COUNT = 3'b100
  } ch_state_t;

  typedef struct packed {
    ch_state_t        st;
    logic [CNT_W-1:0] cnt;
    logic             uflow;
  } chan_t;

  chan_t s_r;
  chan_t s_nxt;
  logic  tick;

  // selected timer clock
  always_comb begin
    unique case (clk_sel_t'(ch.clkSel))
      SEL_FAST: tick = ch.tickFast;
      SEL_SLOW: tick = ch.tickSlow;
      SEL_WAKE: tick = ch.tickWake;
      default:  tick = 1'b0;
    endcase
  end

  // counting sequence
  always_comb begin
    s_nxt       = s_r;
    s_nxt.uflow = 1'b0;
    if (ch.stopCmd) begin
      s_nxt.st = CH_IDLE;
    end else if (ch.startCmd) begin
      s_nxt.cnt = ch.reload;
      s_nxt.st  = ch.startSel ? CH_ARMED : CH_COUNT;
    end else begin
      unique case (s_r.st)
        CH_IDLE: begin
        end
        CH_ARMED: begin
          if (ch.startEvt) begin
            s_nxt.st = CH_COUNT;
          end
        end
        CH_COUNT: begin
          if (ch.stopEn && ch.stopEvt) begin
            s_nxt.st = CH_IDLE;
          end else if (tick) begin
            if (s_r.cnt == COUNT_RST) begin
              s_nxt.uflow = 1'b1;
              if (ch.autoReload) begin
                s_nxt.cnt = ch.reload;
              end else begin
                s_nxt.st = CH_IDLE;
              end
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end
        end
        default: s_nxt.st = CH_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: CH_IDLE, cnt: COUNT_RST, uflow: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // status back to the register file
  assign ch.count     = s_r.cnt;
  assign ch.running   = (s_r.st != CH_IDLE);
  assign ch.underflow = s_r.uflow;

endmodule
`default_nettype wire

// >>> test/reader_timer_unit_props.sv
`timescale 1ns/1ns
`default_nettype none
module reader_timer_unit_props
  import timer_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wrEn,
  input wire logic              rdEn,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              detectDone,
  input wire logic              cardFound,
  input wire logic              standbyOn,
  input wire logic              irq
);
  // ****************************************************
  // bus, interrupt and standby checks
  // ****************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // stop command for timer 0, other timers' bits not checked
  sequence stopT0;
    wrEn && addr == GLOBAL_CTRL_OFS && wdata[GC_NOW_LSB] &&
      !wdata[GC_RUN_LSB];
  endsequence
  sequence rdGc;
    rdEn && addr == GLOBAL_CTRL_OFS;
  endsequence
  sequence wrMask;
    wrEn && addr == IRQ_MASK_OFS;
  endsequence
  sequence rdMask;
    rdEn && addr == IRQ_MASK_OFS;
  endsequence

  AST_RDATA_IDLE: assert property (!$past(rdEn) |-> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_MASK_READBACK: assert property (wrMask ##1 !wrEn ##1 rdMask |=>
    rdata == $past(wdata, 3)) else $error("mask read back differs");
  AST_MASK_OFF_QUIET: assert property (wrMask and (wdata == 8'h00) |=>
    !irq) else $error("interrupt with all sources masked");
  AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> $past(wrEn))
    else $error("interrupt dropped without a write");
  AST_STBY_RISE_CAUSE: assert property ($rose(standbyOn) |->
    $past(wrEn) || $past(wrEn, 2) || ($past(detectDone) && !$past(cardFound)))
    else $error("standby entered without cause");
  AST_CARD_STAYS_UP: assert property (detectDone && cardFound &&
    !standbyOn && !wrEn && !$past(wrEn) |=> !standbyOn)
    else $error("standby entered with card found");
  AST_STOP_SHOWS_IDLE: assert property (stopT0 ##1 !wrEn ##1 !wrEn
    ##1 rdGc |=> !rdata[GC_RUN_LSB]) else $error("stopped timer runs");
  AST_NOW_BIT_ZERO: assert property (rdEn && addr == WAKE_CTRL_OFS |=>
    !rdata[WC_ENTER_STBY_POS]) else $error("standby now bit reads one");
  AST_UNMAPPED_ZERO: assert property (rdEn && addr == 8'h08 |=>
    rdata == 8'h00) else $error("unmapped read not zero");
endmodule

bind reader_timer_unit reader_timer_unit_props chk (.clk(clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata),
  .detectDone(detectDone), .cardFound(cardFound), .standbyOn(standbyOn),
  .irq(irq));
`default_nettype wire

// >>> test/tb_reader_timer_unit.sv
`timescale 1ns/1ns
`default_nettype none
module tb_reader_timer_unit;
  import timer_pkg::*;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wrEn;
  logic              rdEn;
  logic [DATA_W-1:0] rdata;
  logic              lfoClkPin;
  logic              startEvtPin;
  logic              stopEvtPin;
  logic              detectDone;
  logic              cardFound;
  logic              standbyOn;
  logic              irq;
  logic [DATA_W-1:0] rv;
  int                errors;
  int                testsRun;

  reader_timer_unit uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .lfoClkPin(lfoClkPin),
    .startEvtPin(startEvtPin), .stopEvtPin(stopEvtPin),
    .detectDone(detectDone), .cardFound(cardFound), .standbyOn(standbyOn),
    .irq(irq));

  // ****************************************************
  // helpers
  // ****************************************************
  always #4 clk = ~clk;

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  function automatic logic [7:0] ta(input int x, input logic [2:0] s);
    return TIMER_BASE_OFS + TIMER_STRIDE * 8'(x) + {5'h00, s};
  endfunction
  task automatic setup(input int x, input logic [7:0] c,
                       input logic [15:0] r);
    wr(ta(x, T_CTRL_SUB), c);
    wr(ta(x, T_RELOAD_LO_SUB), r[7:0]);
    wr(ta(x, T_RELOAD_HI_SUB), r[15:8]);
  endtask
  task automatic start(input logic [7:0] v);
    wr(GLOBAL_CTRL_OFS, v);
    @(posedge clk);
  endtask
  task automatic cnt(input int x, input logic [15:0] e, input string m);
    logic [7:0] lo;
    rd(ta(x, T_COUNT_LO_SUB), lo);
    rd(ta(x, T_COUNT_HI_SUB), rv);
    chk({rv, lo}, e, m);
  endtask
  task automatic bitIs(input logic [7:0] a, input int p, input logic e,
                       input string m);
    rd(a, rv);
    chk({15'h0000, rv[p]}, {15'h0000, e}, m);
  endtask
  task automatic pins(input logic ei, input logic es, input string m);
    #1 chk({15'h0000, irq}, {15'h0000, ei}, {m, " irq"});
    chk({15'h0000, standbyOn}, {15'h0000, es}, {m, " standby"});
    @(posedge clk);
  endtask
  // one slow oscillator period: 4 cycles high, 8 low
  task automatic low_freq_oscillator(input int n);
    repeat (n) begin
      lfoClkPin <= 1'b1;
      repeat (4) @(posedge clk);
      lfoClkPin <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic pulse(input logic s);
    if (s) startEvtPin <= 1'b1;
    else stopEvtPin <= 1'b1;
    repeat (4) @(posedge clk);
    startEvtPin <= 1'b0;
    stopEvtPin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic detect(input logic c);
    cardFound <= c;
    detectDone <= 1'b1;
    @(posedge clk);
    detectDone <= 1'b0;
    @(posedge clk);
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic testReset;
    for (int a = 0; a < 4; a++) begin
      rd(8'(a), rv);
      chk({8'h00, rv}, 16'h0000, "reset value");
    end
    rd(8'h08, rv);
    chk({8'h00, rv}, 16'h0000, "unmapped read");
    wr(IRQ_MASK_OFS, 8'h2a);
    rd(IRQ_MASK_OFS, rv);
    chk({8'h00, rv}, 16'h002a, "mask readback");
    pins(1'b0, 1'b0, "after reset");
    $display("test reset done");
  endtask
  task automatic testOneShot;
    wr(WAKE_CTRL_OFS, 8'h03);
    setup(0, 8'h02, 16'h0003);
    wr(IRQ_MASK_OFS, 8'h01);
    start(8'h11);
    cnt(0, 16'h0003, "load on start");
    low_freq_oscillator(3);
    cnt(0, 16'h0000, "counted to zero");
    pins(1'b0, 1'b0, "at zero");
    low_freq_oscillator(1);
    pins(1'b1, 1'b0, "one shot");
    bitIs(IRQ_STATUS_OFS, 0, 1'b1, "flag t0");
    bitIs(GLOBAL_CTRL_OFS, 0, 1'b0, "stop at zero");
    wr(IRQ_STATUS_OFS, 8'hff);
    pins(1'b0, 1'b0, "cleared");
    $display("test one shot done");
  endtask
  task automatic testStopWatch;
    setup(1, 8'h12, 16'h0005);
    wr(IRQ_MASK_OFS, 8'h02);
    start(8'h22);
    low_freq_oscillator(2);
    pulse(1'b0);
    low_freq_oscillator(4);
    cnt(1, 16'h0003, "frozen count");
    bitIs(IRQ_STATUS_OFS, 1, 1'b0, "no flag");
    pins(1'b0, 1'b0, "stopped early");
    bitIs(GLOBAL_CTRL_OFS, 1, 1'b0, "t1 halted");
    $display("test stop watch done");
  endtask
  task automatic testPeriodic;
    setup(2, 8'h06, 16'h0001);
    wr(IRQ_MASK_OFS, 8'h04);
    start(8'h44);
    repeat (2) begin
      low_freq_oscillator(2);
      pins(1'b1, 1'b0, "period");
      wr(IRQ_STATUS_OFS, 8'h04);
      pins(1'b0, 1'b0, "period clear");
    end
    bitIs(GLOBAL_CTRL_OFS, 2, 1'b1, "still running");
    wr(GLOBAL_CTRL_OFS, 8'h40);
    $display("test periodic done");
  endtask
  task automatic testNoEnable;
    wr(IRQ_MASK_OFS, 8'h00);
    setup(3, 8'h02, 16'h0000);
    start(8'h88);
    low_freq_oscillator(1);
    bitIs(IRQ_STATUS_OFS, 3, 1'b1, "flag unmasked off");
    pins(1'b0, 1'b0, "masked");
    wr(IRQ_STATUS_OFS, 8'hff);
    $display("test no enable done");
  endtask
  task automatic testStartEvt;
    setup(0, 8'h0a, 16'h0002);
    start(8'h11);
    low_freq_oscillator(2);
    pulse(1'b1);
    low_freq_oscillator(1);
    cnt(0, 16'h0001, "counts from event");
    wr(GLOBAL_CTRL_OFS, 8'h10);
    @(posedge clk);
    bitIs(GLOBAL_CTRL_OFS, 0, 1'b0, "stop write");
    $display("test start event done");
  endtask
  // fast timer needs 10 ticks, slow one 2 ticks of about 590 cycles
  task automatic testClkSrc;
    wr(IRQ_MASK_OFS, 8'h00);
    setup(1, 8'h00, 16'h0009);
    setup(2, 8'h01, 16'h0001);
    start(8'h66);
    repeat (60) @(posedge clk);
    bitIs(IRQ_STATUS_OFS, 1, 1'b0, "fast not yet");
    repeat (60) @(posedge clk);
    bitIs(IRQ_STATUS_OFS, 1, 1'b1, "fast underflow");
    bitIs(IRQ_STATUS_OFS, 2, 1'b0, "slow not yet");
    repeat (1200) @(posedge clk);
    bitIs(IRQ_STATUS_OFS, 2, 1'b1, "slow underflow");
    wr(IRQ_STATUS_OFS, 8'hff);
    $display("test clock source done");
  endtask
  task automatic testWake;
    wr(WAKE_CTRL_OFS, 8'h0f);
    pins(1'b0, 1'b1, "standby now");
    bitIs(WAKE_CTRL_OFS, WC_ENTER_STBY_POS, 1'b0, "now bit");
    low_freq_oscillator(1);
    pins(1'b0, 1'b0, "wake up");
    detect(1'b0);
    pins(1'b0, 1'b1, "empty detect");
    low_freq_oscillator(1);
    pins(1'b0, 1'b0, "wake again");
    detect(1'b1);
    pins(1'b0, 1'b0, "card found");
    bitIs(IRQ_STATUS_OFS, IRQ_CARD_POS, 1'b1, "card flag");
    wr(WAKE_CTRL_OFS, 8'h03);
    detect(1'b0);
    pins(1'b0, 1'b0, "stay powered");
    $display("test wake done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wrEn = 1'b0;
    rdEn = 1'b0;
    lfoClkPin = 1'b0;
    startEvtPin = 1'b0;
    stopEvtPin = 1'b0;
    detectDone = 1'b0;
    cardFound = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    testReset;
    testOneShot;
    testStopWatch;
    testPeriodic;
    testNoEnable;
    testStartEvt;
    testClkSrc;
    testWake;
    complete_run;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
